//--- src/sink_driver.sv
// Serial-in, latched, 32-stage sink driver core.
// Assumes all pins are asynchronous and sampled by sys_clk at 100 MHz.
`timescale 1ns/1ps
`include "sink_driver_defines.svh"

module sink_driver
(
  input wire logic sys_clk,
  input wire logic nrst,
  input sink_driver_pkg::pin_in_t pins,
  output logic serial_out,
  output sink_driver_pkg::stage_vec_t sink_on,
  output logic overrun
);

  import sink_driver_pkg::*;

  // ****************************************************************
  // Pin conditioning
  // ****************************************************************
  pin_in_t clean;
  logic clk_prev_r;
  logic clk_prev_nxt;
  logic clk_rise;

  pin_sync u_sync (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .pins(pins),
    .pins_clean(clean)
  );

  // Data and clock share the same filter delay, so the data level seen
  // at the detected edge is the level that stood at the pin edge
  assign clk_rise = clean.shift_clk && !clk_prev_r;

  always_comb
  begin
    clk_prev_nxt = clean.shift_clk;
  end

  // ****************************************************************
  // Bit buffer
  // ****************************************************************
  logic buf_in_ready;
  logic buf_out_valid;
  logic buf_out_bit;
  logic take;
  logic overrun_r;
  logic overrun_nxt;

  bit_buffer u_buf (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .in_valid(clk_rise),
    .in_ready(buf_in_ready),
    .in_bit(clean.serial_data),
    .out_valid(buf_out_valid),
    .out_ready(take),
    .out_bit(buf_out_bit)
  );

  // Sticky: a bit lost to a full buffer cannot be recovered
  always_comb
  begin
    overrun_nxt = overrun_r || (clk_rise && !buf_in_ready);
  end

  // ****************************************************************
  // Shift register
  // ****************************************************************
  drain_phase_t phase_r;
  drain_phase_t phase_nxt;
  stage_vec_t shift_r;
  stage_vec_t shift_nxt;

  logic shift_en;
  stage_vec_t shift_in;

  // Shift stage drains one bit every other cycle, trading rate for a
  // settle cycle in which the latch sees a stable register
  assign take = buf_out_valid && (phase_r == PH_TAKE);
  assign shift_in = {shift_r[`SD_STAGES-2:0], buf_out_bit};

  always_comb
  begin
    shift_en = 1'b0;
    phase_nxt = phase_r;
    case (phase_r)
      PH_TAKE:
      begin
        if (take)
        begin
          shift_en = 1'b1;
          phase_nxt = PH_SETTLE;
        end
      end
      PH_SETTLE:
      begin
        phase_nxt = PH_TAKE;
      end
      default:
      begin
        phase_nxt = PH_TAKE;
      end
    endcase
  end

  // Stage 0 takes the drained bit, each later stage its lower neighbour
  genvar g;
  generate
    for (g = 0; g < `SD_STAGES; g = g + 1)
    begin : gen_stage
      always_comb
      begin
        if (shift_en)
        begin
          shift_nxt[g] = shift_in[g];
        end
        else
        begin
          shift_nxt[g] = shift_r[g];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Latch bank
  // ****************************************************************
  stage_vec_t latch_r;
  stage_vec_t latch_nxt;

  // Strobe is the only load term; enable never enters here
  genvar s;
  generate
    for (s = 0; s < `SD_STAGES; s = s + 1)
    begin : gen_latch
      always_comb
      begin
        if (clean.strobe)
        begin
          latch_nxt[s] = shift_nxt[s];
        end
        else
        begin
          latch_nxt[s] = latch_r[s];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Cascade output
  // ****************************************************************
  logic serial_out_r;
  logic serial_out_nxt;

  // Last stage straight out, so devices chain with no glue
  always_comb
  begin
    serial_out_nxt = shift_nxt[`SD_STAGES-1];
  end

  // ****************************************************************
  // Sink outputs
  // ****************************************************************
  stage_vec_t sink_r;
  stage_vec_t sink_nxt;
  stage_vec_t sink_off;

  // Every sink released while the bank is disabled
  assign sink_off = `SD_SINK_OFF;

  // Gated from the latch next value, so sink and latch move together
  genvar t;
  generate
    for (t = 0; t < `SD_STAGES; t = t + 1)
    begin : gen_sink
      always_comb
      begin
        if (clean.out_enable)
        begin
          sink_nxt[t] = latch_nxt[t];
        end
        else
        begin
          sink_nxt[t] = sink_off[t];
        end
      end
    end
  endgenerate

  assign serial_out = serial_out_r;
  assign sink_on = sink_r;
  assign overrun = overrun_r;

  // ****************************************************************
  // State registers
  // ****************************************************************
  // Reset to a known pattern; without it, software must load first
  // Edge detector idles low like the pin, so reset makes no false edge
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      clk_prev_r <= 1'b0;
    end
    else
    begin
      clk_prev_r <= clk_prev_nxt;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      overrun_r <= 1'b0;
    end
    else
    begin
      overrun_r <= overrun_nxt;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      phase_r <= PH_TAKE;
    end
    else
    begin
      phase_r <= phase_nxt;
    end
  end

  // Phase and stages clear together, so no half-drained bit survives
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      shift_r <= `SD_SHIFT_RST;
    end
    else
    begin
      shift_r <= shift_nxt;
    end
  end

  // Latch reset keeps every sink off until a pattern is loaded
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      latch_r <= `SD_LATCH_RST;
    end
    else
    begin
      latch_r <= latch_nxt;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      serial_out_r <= 1'b0;
    end
    else
    begin
      serial_out_r <= serial_out_nxt;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      sink_r <= `SD_SINK_OFF;
    end
    else
    begin
      sink_r <= sink_nxt;
    end
  end

endmodule

//--- src/sink_driver_defines.svh
// Constants for the latched sink driver: widths and synchroniser depth.
// Assumes inclusion by bare name from the package and design files.
`ifndef SINK_DRIVER_DEFINES_SVH
`define SINK_DRIVER_DEFINES_SVH

// ****************************************************************
// Widths
// ****************************************************************
`define SD_STAGES 32
`define SD_PIN_COUNT 4
`define SD_SYNC_DEPTH 3
`define SD_BUF_DEPTH 2

// ****************************************************************
// Reset values
// ****************************************************************
`define SD_SHIFT_RST 32'h00000000
`define SD_LATCH_RST 32'h00000000
`define SD_SINK_OFF 32'h00000000

`endif

//--- src/sink_driver_pkg.sv
// Types shared by the sink driver design files.
// Assumes the defines header is on the include path.
`include "sink_driver_defines.svh"

package sink_driver_pkg;

  // ****************************************************************
  // Pin group
  // ****************************************************************
  typedef struct packed {
    logic shift_clk;
    logic serial_data;
    logic strobe;
    logic out_enable;
  } pin_in_t;

  typedef logic [`SD_STAGES-1:0] stage_vec_t;

  // ****************************************************************
  // Drain phase of the shift stage
  // ****************************************************************
  typedef enum logic {
    PH_TAKE,
    PH_SETTLE
  } drain_phase_t;

endpackage

//--- src/pin_sync.sv
// Three-flop synchroniser with agreement filter for the pin group.
// Assumes pins are asynchronous to sys_clk; nrst is synchronous.
`timescale 1ns/1ps
`include "sink_driver_defines.svh"

module pin_sync
  import sink_driver_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input sink_driver_pkg::pin_in_t pins,
  output sink_driver_pkg::pin_in_t pins_clean
);

  logic [`SD_PIN_COUNT-1:0] raw;
  logic [`SD_PIN_COUNT-1:0] s1_r;
  logic [`SD_PIN_COUNT-1:0] s2_r;
  logic [`SD_PIN_COUNT-1:0] s3_r;
  logic [`SD_PIN_COUNT-1:0] clean_r;
  logic [`SD_PIN_COUNT-1:0] clean_nxt;

  assign raw = pins;
  assign pins_clean = clean_r;

  // ****************************************************************
  // Per-pin filter
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < `SD_PIN_COUNT; g = g + 1)
    begin : gen_pin
      // Change counts only once second and third flops agree
      always_comb
      begin
        clean_nxt[g] = (s2_r[g] == s3_r[g]) ? s3_r[g] : clean_r[g];
      end
    end
  endgenerate

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      clean_r <= '0;
    end
    else
    begin
      s1_r <= raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      clean_r <= clean_nxt;
    end
  end

endmodule

//--- src/bit_buffer.sv
// Two-entry valid/ready buffer for sampled serial bits.
// Assumes a single clock domain and synchronous active-low reset.
`timescale 1ns/1ps
`include "sink_driver_defines.svh"

module bit_buffer (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic in_bit,
  output logic out_valid,
  input wire logic out_ready,
  output logic out_bit
);

  logic [`SD_BUF_DEPTH-1:0] mem_r;
  logic [`SD_BUF_DEPTH-1:0] mem_nxt;
  logic [1:0] count_r;
  logic [1:0] count_nxt;
  logic rd_r;
  logic rd_nxt;
  logic wr_r;
  logic wr_nxt;
  logic push;
  logic pop;

  assign in_ready = (count_r != 2'h2);
  assign out_valid = (count_r != 2'h0);
  assign out_bit = mem_r[rd_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb
  begin
    mem_nxt = mem_r;
    rd_nxt = rd_r;
    wr_nxt = wr_r;
    count_nxt = count_r;
    if (push)
    begin
      mem_nxt[wr_r] = in_bit;
      wr_nxt = ~wr_r;
    end
    if (pop)
    begin
      rd_nxt = ~rd_r;
    end
    if (push && !pop)
    begin
      count_nxt = count_r + 2'h1;
    end
    else if (pop && !push)
    begin
      count_nxt = count_r - 2'h1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      mem_r <= '0;
      rd_r <= 1'b0;
      wr_r <= 1'b0;
      count_r <= 2'h0;
    end
    else
    begin
      mem_r <= mem_nxt;
      rd_r <= rd_nxt;
      wr_r <= wr_nxt;
      count_r <= count_nxt;
    end
  end

endmodule

//--- dv/sink_driver_props.sv
// Checker on the sink driver ports.
// Assumes binding to sink_driver; pins are seen raw.
`timescale 1ns/1ps
module sink_driver_props
  import sink_driver_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input sink_driver_pkg::pin_in_t pins,
  input wire logic serial_out,
  input sink_driver_pkg::stage_vec_t sink_on
);
  // *****
  // Quiet span
  // *****
  logic en_r, en_nxt, keep_r, keep_nxt;
  logic [3:0] quiet_r, quiet_nxt;
  stage_vec_t held_r, held_nxt;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  always_comb
  begin
    en_nxt = pins.out_enable;
    keep_nxt = keep_r && !pins.strobe;
    held_nxt = held_r;
    quiet_nxt = quiet_r + {3'h0, quiet_r != 4'hf};
    if (pins.strobe || pins.out_enable != en_r)
      quiet_nxt = 4'h0;
    if (pins.out_enable && quiet_r >= 4'hc)
    begin
      keep_nxt = !pins.strobe;
      held_nxt = sink_on;
    end
  end
  always_ff @(posedge sys_clk)
  begin
    en_r <= en_nxt;
    held_r <= held_nxt;
    quiet_r <= nrst ? quiet_nxt : 4'h0;
    keep_r <= nrst && keep_nxt;
  end
  // *****
  // Properties
  // *****
  a_off_when_disabled: assert property (
    !pins.out_enable [*8] |-> sink_on == '0) else $error("sink on");
  a_disable_bound: assert property (
    $fell(pins.out_enable) |-> ##[4:8] sink_on == '0)
    else $error("slow off");
  a_serial_needs_edge: assert property (
    $changed(serial_out) |-> $past(pins.shift_clk, 4))
    else $error("serial moved");
  a_shift_idle_hold: assert property (
    !pins.shift_clk [*8] |-> $stable(serial_out)) else $error("drift");
  a_latch_idle_hold: assert property (
    quiet_r >= 4'hc |-> $stable(sink_on)) else $error("latch moved");
  a_transparent_tail: assert property (
    (pins.strobe && pins.out_enable) [*8] |-> sink_on[31] == serial_out)
    else $error("not tracking");
  a_enable_keeps_latch: assert property (
    keep_r && pins.out_enable && quiet_r == 4'hc |-> sink_on == held_r)
    else $error("latch lost");
  a_sink_needs_enable: assert property (
    $rose(|sink_on) |-> $past(pins.out_enable, 3)) else $error("early");
endmodule
bind sink_driver sink_driver_props u_props (.sys_clk(sys_clk),
  .nrst(nrst), .pins(pins), .serial_out(serial_out), .sink_on(sink_on));

//--- dv/ctrl_model.sv
// Controller model driving the sink driver pins.
// Assumes sys_clk paces every pin change.
`timescale 1ns/1ps
module ctrl_model
  import sink_driver_pkg::*;
(
  input wire logic sys_clk,
  output sink_driver_pkg::pin_in_t pins
);
  // *****
  // Pin tasks
  // *****
  initial pins = '0;
  // Long settle so the pin filter always catches up
  task automatic set_ctl(input logic stb, input logic en);
    @(posedge sys_clk);
    pins.strobe <= stb;
    pins.out_enable <= en;
    repeat (10) @(posedge sys_clk);
  endtask
  // Low phase of 5 or 6 averages a 125 ns period
  task automatic send(input stage_vec_t word, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge sys_clk);
      pins.shift_clk <= 1'b0;
      pins.serial_data <= word[31 - i];
      repeat (5 + i % 2) @(posedge sys_clk);
      pins.shift_clk <= 1'b1;
      repeat (6) @(posedge sys_clk);
    end
    @(posedge sys_clk);
    pins.shift_clk <= 1'b0;
    pins.serial_data <= ~word[32 - n];
    repeat (10) @(posedge sys_clk);
  endtask
endmodule

//--- dv/tb_sink_driver.sv
// Self-checking bench for the sink driver.
// Assumes package, design, checker and model compiled first.
`timescale 1ns/1ps
module tb_sink_driver;
  import sink_driver_pkg::*;
  localparam stage_vec_t PAT_A = 32'h8e3c71a5;
  localparam stage_vec_t PAT_B = 32'h5a0fc3e1;
  localparam stage_vec_t PAT_C = 32'h96e13b4d;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  pin_in_t pins;
  logic serial_out;
  stage_vec_t sink_on;
  logic overrun;
  int err_total = 0;
  int compares = 0;
  always #5 sys_clk = ~sys_clk;
  ctrl_model ctrl (.sys_clk(sys_clk), .pins(pins));
  sink_driver dut (.sys_clk(sys_clk), .nrst(nrst), .pins(pins),
    .serial_out(serial_out), .sink_on(sink_on), .overrun(overrun));
  // *****
  // Checking
  // *****
  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task test_done;
    $display("Compares %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // *****
  // Scenarios
  // *****
  // Reset clears every stage, so all outputs read zero
  task t_cleared;
    check("sinks reset", sink_on, '0);
    check("serial reset", {31'h0, serial_out}, 32'h0);
    check("overrun reset", {31'h0, overrun}, 32'h0);
  endtask
  task t_load;
    ctrl.set_ctl(1'b0, 1'b0);
    ctrl.send(PAT_A, 32);
    check("off", sink_on, '0);
    ctrl.set_ctl(1'b1, 1'b0);
    check("off latched", sink_on, '0);
    ctrl.set_ctl(1'b0, 1'b1);
    check("loaded", sink_on, PAT_A);
    check("tail", {31'h0, serial_out}, {31'h0, PAT_A[31]});
  endtask
  task t_hold;
    ctrl.send(PAT_B, 32);
    check("hold", sink_on, PAT_A);
    check("tail", {31'h0, serial_out}, {31'h0, PAT_B[31]});
    ctrl.set_ctl(1'b0, 1'b0);
    check("disabled", sink_on, '0);
    ctrl.set_ctl(1'b0, 1'b1);
    check("kept", sink_on, PAT_A);
    ctrl.set_ctl(1'b1, 1'b1);
    check("transparent", sink_on, PAT_B);
  endtask
  // Enable held low, so sinks stay off while shifting through open latches
  task t_track;
    ctrl.set_ctl(1'b1, 1'b0);
    ctrl.send(PAT_C, 16);
    ctrl.set_ctl(1'b1, 1'b1);
    check("tracking", sink_on, {PAT_B[15:0], PAT_C[31:16]});
    check("mid", {31'h0, serial_out}, {31'h0, PAT_B[15]});
    check("overrun", {31'h0, overrun}, 32'h0);
  endtask
  // Mid-run reset, then a fresh load through bypassed latches
  task t_rerun;
    @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (5) @(posedge sys_clk);
    t_cleared;
    nrst <= 1'b1;
    repeat (10) @(posedge sys_clk);
    t_cleared;
    ctrl.set_ctl(1'b1, 1'b0);
    ctrl.send(PAT_C, 32);
    check("bypassed off", sink_on, '0);
    ctrl.set_ctl(1'b0, 1'b1);
    check("reloaded", sink_on, PAT_C);
    check("tail", {31'h0, serial_out}, {31'h0, PAT_C[31]});
  endtask
  initial
  begin
    repeat (10) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (5) @(posedge sys_clk);
    t_cleared;
    t_load;
    t_hold;
    t_track;
    t_rerun;
    test_done;
  end
  // About 15 us of traffic; generous margin
  initial
  begin
    #200000;
    err_total++;
    test_done;
  end
endmodule
